// [rtl/dapr_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none

module dapr_ctrl (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic resetPinN,
    input wire logic pixelClockInput,
    input wire dapr_pkg::dapr_pins_t pinsIn,
    input wire logic [1:0] cableSense,
    input wire logic frameStart,
    input wire logic spiSelect,
    input wire dapr_pkg::dapr_req_t hostReq,
    output logic [7:0] rdData_r,
    output logic rdValid_r,
    output logic [2:0] dacPower_r,
    output logic hostControlPortSpi_r
);
    import dapr_pkg::*;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic resetPinMeta_r, resetPinSync_r, resetPinOld_r;
    logic pixClkMeta_r, pixClkSync_r, pixClkOld_r;
    logic [1:0] senseMeta_r, senseSync_r;
    dapr_pins_t pinsMeta_r, pinsSync_r;

    // Two flip-flops on every asynchronous input.
    always_ff @(posedge clk_sys) begin
        resetPinMeta_r <= resetPinN;
        resetPinSync_r <= resetPinMeta_r;
        pixClkMeta_r <= pixelClockInput;
        pixClkSync_r <= pixClkMeta_r;
        senseMeta_r <= cableSense;
        senseSync_r <= senseMeta_r;
        pinsMeta_r <= pinsIn;
        pinsSync_r <= pinsMeta_r;
    end

    // Edge history, set in reset to reset pin high and pixel clock low, so an input at the other level gives an edge after release.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            resetPinOld_r <= 1'b1;
            pixClkOld_r <= 1'b0;
        end else begin
            resetPinOld_r <= resetPinSync_r;
            pixClkOld_r <= pixClkSync_r;
        end
    end

    // ----------------------------------------------------------------
    // Reset sources
    // ----------------------------------------------------------------
    logic hwReset, swReset, anyReset, pixEdge;
    assign hwReset = resetPinOld_r && !resetPinSync_r;
    assign swReset = hostReq.wr && hostReq.addr == DAPR_OFS_SOFTRST && hostReq.wdata[DAPR_BIT_SWRST];
    assign anyReset = reset || hwReset || swReset;
    assign pixEdge = pixClkSync_r && !pixClkOld_r;

    // Port mode: only power-on or the reset pin returns it to I2C.
    always_ff @(posedge clk_sys) begin
        if (reset || hwReset) begin
            hostControlPortSpi_r <= 1'b0;
        end else if (spiSelect) begin
            hostControlPortSpi_r <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    logic [7:0] powerCtrl_r, inMode_r, outCfg_r;
    logic cdEn_r, apdEn_r;

    // Writable registers; any reset source restores the defaults.
    always_ff @(posedge clk_sys) begin
        if (anyReset) begin
            powerCtrl_r <= DAPR_RST_POWER;
            inMode_r <= DAPR_RST_INMODE;
            outCfg_r <= DAPR_RST_OUTCFG;
            cdEn_r <= DAPR_RST_CABLE[DAPR_BIT_CDEN];
            apdEn_r <= DAPR_RST_CABLE[DAPR_BIT_APDEN];
        end else if (hostReq.wr) begin
            case (hostReq.addr)
                DAPR_OFS_POWER: powerCtrl_r <= hostReq.wdata;
                DAPR_OFS_INMODE: inMode_r <= hostReq.wdata;
                DAPR_OFS_OUTCFG: outCfg_r <= hostReq.wdata;
                DAPR_OFS_CABLE: begin
                    cdEn_r <= hostReq.wdata[DAPR_BIT_CDEN];
                    apdEn_r <= hostReq.wdata[DAPR_BIT_APDEN];
                end
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Cable detection and auto power-down
    // ----------------------------------------------------------------
    logic [1:0] cableStat_r;
    logic [2:0] autoOff_r;
    logic component, mon1, mon2, autoActive;
    assign component = outCfg_r[DAPR_BIT_COMPONENT];
    assign mon1 = cdEn_r && powerCtrl_r[0];
    assign mon2 = cdEn_r && powerCtrl_r[1] && !component;
    assign autoActive = apdEn_r && cdEn_r;

    // Status of each monitored cable (mon1, mon2) is refreshed at frame start; 1 means no cable.
    always_ff @(posedge clk_sys) begin
        if (anyReset) begin
            cableStat_r <= DAPR_RST_CABLE[1:0];
        end else if (frameStart) begin
            if (mon1) begin
                cableStat_r[DAPR_BIT_STAT1] <= !senseSync_r[0];
            end
            if (mon2) begin
                cableStat_r[DAPR_BIT_STAT2] <= !senseSync_r[1];
            end
        end
    end

    // Per-frame shutdown decision, held for the whole frame.
    always_ff @(posedge clk_sys) begin
        if (anyReset || !autoActive) begin
            autoOff_r <= DAPR_DAC_NONE;
        end else if (frameStart) begin
            autoOff_r <= DAPR_DAC_NONE;
            if (component) begin
                if (mon1 && !senseSync_r[0]) begin
                    autoOff_r <= DAPR_DAC_ALL;
                end
            end else begin
                if (mon1 && !senseSync_r[0]) begin
                    autoOff_r[0] <= 1'b1;
                end
                if (mon2 && !senseSync_r[1]) begin
                    autoOff_r[2:1] <= DAPR_DAC23[2:1];
                end
            end
        end
    end

    // DAC power enables: host setting less any automatic shutdown.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            dacPower_r <= DAPR_DAC_NONE;
        end else begin
            dacPower_r <= powerCtrl_r[2:0] & ~autoOff_r;
        end
    end

    // ----------------------------------------------------------------
    // Pin readback
    // ----------------------------------------------------------------
    dapr_pins_t rbPins_r;

    // Levels are latched on each rising edge of the pixel clock.
    always_ff @(posedge clk_sys) begin
        if (anyReset) begin
            rbPins_r <= '0;
        end else if (pixEdge) begin
            rbPins_r <= pinsSync_r;
        end
    end

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    // Read data one cycle after the request; unmapped offsets read 0.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rdData_r <= DAPR_ZERO;
            rdValid_r <= 1'b0;
        end else begin
            rdValid_r <= hostReq.rd;
            case (hostReq.addr)
                DAPR_OFS_POWER: rdData_r <= powerCtrl_r;
                DAPR_OFS_INMODE: rdData_r <= inMode_r;
                DAPR_OFS_OUTCFG: rdData_r <= outCfg_r;
                DAPR_OFS_CABLE: rdData_r <= {3'h0, apdEn_r, 1'b0, cdEn_r, cableStat_r};
                DAPR_OFS_RBA: rdData_r <= rbPins_r.pix[7:0];
                DAPR_OFS_RBB: rdData_r <= rbPins_r.pix[15:8];
                DAPR_OFS_RBC: rdData_r <= {5'h00, rbPins_r.subLock, rbPins_r.vsync, rbPins_r.hsync};
                DAPR_OFS_SOFTRST: rdData_r <= DAPR_ZERO;
                default: rdData_r <= DAPR_ZERO;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence frameNoCable1;
        frameStart && autoActive && mon1 && !senseSync_r[0] && !anyReset && !hostReq.wr;
    endsequence

    sequence quietCycle;
        !anyReset && !hostReq.wr;
    endsequence

    soft_reset_a: assert property (swReset |=> powerCtrl_r == DAPR_RST_POWER) else $error("soft reset missed");
    self_clear_a: assert property (hostReq.rd && hostReq.addr == DAPR_OFS_SOFTRST
        |=> rdValid_r && rdData_r[DAPR_BIT_SWRST] == 1'b0) else $error("soft reset bit not clear");
    hw_port_a: assert property (hwReset |=> !hostControlPortSpi_r) else $error("port not back to I2C");
    spi_keep_a: assert property (swReset && !hwReset && hostControlPortSpi_r |=> hostControlPortSpi_r)
        else $error("soft reset left SPI");
    hw_regs_a: assert property (hwReset |=> powerCtrl_r == DAPR_RST_POWER && !cdEn_r && !apdEn_r)
        else $error("hw reset missed");
    stat_update_a: assert property (frameStart && mon1 && !anyReset
        |=> cableStat_r[DAPR_BIT_STAT1] == !$past(senseSync_r[0])) else $error("status bit wrong");
    comp_all_off_a: assert property (frameNoCable1 ##0 component ##1 quietCycle |=> dacPower_r == DAPR_DAC_NONE)
        else $error("component not all off");
    // The second group drops only when its own cable is missing, which is excluded here, so only the first DAC may drop.
    cvbs_one_off_a: assert property (frameNoCable1 ##0 !component && !(mon2 && !senseSync_r[1])
        ##1 quietCycle |=> dacPower_r[0] == 1'b0 && dacPower_r[2:1] == powerCtrl_r[2:1])
        else $error("only DAC1 should be off");
    cvbs_two_off_a: assert property (frameStart && autoActive && mon2 && !senseSync_r[1] && !anyReset
        ##1 quietCycle |=> dacPower_r[2:1] == 2'b00) else $error("DAC2 and DAC3 should be off");
    frame_hold_a: assert property (!frameStart && !anyReset && autoActive |=> $stable(autoOff_r))
        else $error("power state changed mid-frame");
    // A shutdown still held when the enables drop clears one cycle later, so the check waits two.
    apd_gate_a: assert property (!autoActive |-> ##2 dacPower_r == $past(powerCtrl_r[2:0]))
        else $error("auto shutdown while disabled");
    readback_a: assert property (pixEdge && !anyReset |=> rbPins_r == $past(pinsSync_r))
        else $error("readback not latched");

endmodule

`default_nettype wire

// [rtl/dapr_pkg.sv]
package dapr_pkg;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] DAPR_OFS_POWER = 8'h00;
    localparam logic [7:0] DAPR_OFS_INMODE = 8'h01;
    localparam logic [7:0] DAPR_OFS_CABLE = 8'h10;
    localparam logic [7:0] DAPR_OFS_RBA = 8'h13;
    localparam logic [7:0] DAPR_OFS_RBB = 8'h14;
    localparam logic [7:0] DAPR_OFS_RBC = 8'h16;
    localparam logic [7:0] DAPR_OFS_SOFTRST = 8'h17;
    localparam logic [7:0] DAPR_OFS_OUTCFG = 8'h18;

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int DAPR_BIT_STAT1 = 0;
    localparam int DAPR_BIT_STAT2 = 1;
    localparam int DAPR_BIT_CDEN = 2;
    localparam int DAPR_BIT_APDEN = 4;
    localparam int DAPR_BIT_SWRST = 1;
    localparam int DAPR_BIT_COMPONENT = 0;
    localparam logic [7:0] DAPR_RST_POWER = 8'h07;
    localparam logic [7:0] DAPR_RST_INMODE = 8'h00;
    localparam logic [7:0] DAPR_RST_CABLE = 8'h03;
    localparam logic [7:0] DAPR_RST_OUTCFG = 8'h00;
    localparam logic [7:0] DAPR_ZERO = 8'h00;
    localparam logic [2:0] DAPR_DAC_NONE = 3'h0;
    localparam logic [2:0] DAPR_DAC_ALL = 3'h7;
    localparam logic [2:0] DAPR_DAC1 = 3'h1;
    localparam logic [2:0] DAPR_DAC23 = 3'h6;

    // Input pin levels that can be read back.
    typedef struct packed {
        logic [15:0] pix;
        logic hsync;
        logic vsync;
        logic subLock;
    } dapr_pins_t;

    // Decoded register access from the host control port.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dapr_req_t;

endpackage

// [verif/dapr_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

// -------------------------------------------------------
// Host controller on the register port
// -------------------------------------------------------
module dapr_host_model (
    input wire logic clk_sys,
    input wire logic [7:0] rdData_r,
    input wire logic rdValid_r,
    output var dapr_pkg::dapr_req_t hostReq
);
    import dapr_pkg::*;

    // The port idles with no request pending.
    initial hostReq = '0;

    // A write is a single-cycle pulse launched on a falling edge.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        hostReq <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
        @(negedge clk_sys);
        hostReq <= '0;
    endtask

    // A read keeps the address up while the answer is collected.
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
        int i;
        @(negedge clk_sys);
        hostReq <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
        @(negedge clk_sys);
        hostReq.rd <= 1'h0;
        ok = 1'h0;
        d = 8'hXX;
        for (i = 0; i < 4 && !ok; i++) begin
            if (rdValid_r === 1'h1) begin
                ok = 1'h1;
                d = rdData_r;
            end else begin
                @(negedge clk_sys);
            end
        end
    endtask
endmodule

`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import dapr_pkg::*;

    logic clk_sys, reset, resetPinN, pixelClockInput, frameStart, spiSelect;
    logic [1:0] cableSense;
    logic [7:0] rdData_r;
    logic rdValid_r, hostControlPortSpi_r;
    logic [2:0] dacPower_r;
    dapr_pins_t pinsIn;
    dapr_req_t hostReq;
    int errCount = 0;
    int nTests = 0;

    dapr_ctrl u_dut (.clk_sys(clk_sys), .reset(reset), .resetPinN(resetPinN),
        .pixelClockInput(pixelClockInput), .pinsIn(pinsIn), .cableSense(cableSense),
        .frameStart(frameStart), .spiSelect(spiSelect), .hostReq(hostReq),
        .rdData_r(rdData_r), .rdValid_r(rdValid_r), .dacPower_r(dacPower_r),
        .hostControlPortSpi_r(hostControlPortSpi_r));
    dapr_host_model u_host (.clk_sys(clk_sys), .rdData_r(rdData_r),
        .rdValid_r(rdValid_r), .hostReq(hostReq));

    // -------------------------------------------------------
    // Shared helpers
    // -------------------------------------------------------
    // Compares one value and counts the outcome.
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        nTests++;
        if (got !== exp) begin
            errCount++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic completeRun();
        $display("comparisons %0d mismatches %0d", nTests, errCount);
        if (errCount == 0 && nTests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Reads a register; a missing answer ends the run.
    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        bit ok;
        u_host.rd(a, d, ok);
        if (!ok) begin
            errCount++;
            completeRun();
        end
        check(d, exp);
    endtask

    // Runs one frame check with the given cable state and checks DAC power.
    task automatic frame(input logic [1:0] cs, input logic [2:0] e);
        @(negedge clk_sys);
        cableSense = cs;
        repeat (4) @(negedge clk_sys);
        frameStart = 1'h1;
        @(negedge clk_sys);
        frameStart = 1'h0;
        repeat (2) @(negedge clk_sys);
        check({5'h00, dacPower_r}, {5'h00, e});
    endtask

    // -------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------
    // Component output: a missing first cable shuts all DACs for one frame.
    task automatic tComponent();
        u_host.wr(DAPR_OFS_OUTCFG, 8'h01);
        u_host.wr(DAPR_OFS_CABLE, 8'h14);
        frame(2'h2, DAPR_DAC_NONE);
        rdChk(DAPR_OFS_CABLE, 8'h17);
        frame(2'h3, DAPR_DAC_ALL);
        rdChk(DAPR_OFS_CABLE, 8'h16);
    endtask

    // Composite output: each missing cable shuts its own group.
    task automatic tComposite();
        u_host.wr(DAPR_OFS_OUTCFG, 8'h00);
        frame(2'h2, DAPR_DAC23);
        frame(2'h1, 3'h1);
        frame(2'h0, DAPR_DAC_NONE);
    endtask

    // Either enable alone leaves power to the power register.
    task automatic tDisabled();
        u_host.wr(DAPR_OFS_CABLE, 8'h10);
        frame(2'h0, DAPR_DAC_ALL);
        u_host.wr(DAPR_OFS_CABLE, 8'h04);
        frame(2'h0, DAPR_DAC_ALL);
        frame(2'h3, DAPR_DAC_ALL);
        rdChk(DAPR_OFS_CABLE, 8'h04);
        u_host.wr(DAPR_OFS_POWER, 8'h06);
        u_host.wr(DAPR_OFS_CABLE, 8'h14);
        frame(2'h2, DAPR_DAC23);
        rdChk(DAPR_OFS_CABLE, 8'h14);
        u_host.wr(DAPR_OFS_POWER, 8'h07);
    endtask

    // Pin levels are captured only on a pixel clock edge.
    task automatic tReadback();
        rdChk(DAPR_OFS_RBA, 8'h00);
        u_host.wr(DAPR_OFS_INMODE, 8'h00);
        pinsIn = '{pix: 16'hA5C3, hsync: 1'h1, vsync: 1'h0, subLock: 1'h1};
        repeat (4) @(negedge clk_sys);
        pixelClockInput = 1'h1;
        repeat (8) @(negedge clk_sys);
        pixelClockInput = 1'h0;
        u_host.wr(DAPR_OFS_RBA, 8'h5A);
        rdChk(DAPR_OFS_RBA, 8'hC3);
        rdChk(DAPR_OFS_RBB, 8'hA5);
        rdChk(DAPR_OFS_RBC, 8'h05);
        pinsIn = '{pix: 16'h3C5A, hsync: 1'h0, vsync: 1'h1, subLock: 1'h0};
        repeat (8) @(negedge clk_sys);
        rdChk(DAPR_OFS_RBA, 8'hC3);
    endtask

    // Software reset keeps SPI mode; the reset pin brings back I2C.
    task automatic tResets();
        rdChk(8'h20, 8'h00);
        spiSelect = 1'h1;
        @(negedge clk_sys);
        spiSelect = 1'h0;
        u_host.wr(DAPR_OFS_OUTCFG, 8'h01);
        u_host.wr(DAPR_OFS_SOFTRST, 8'h02);
        rdChk(DAPR_OFS_CABLE, DAPR_RST_CABLE);
        rdChk(DAPR_OFS_OUTCFG, DAPR_RST_OUTCFG);
        rdChk(DAPR_OFS_SOFTRST, 8'h00);
        check({7'h00, hostControlPortSpi_r}, 8'h01);
        u_host.wr(DAPR_OFS_POWER, 8'h01);
        resetPinN = 1'h0;
        repeat (5) @(negedge clk_sys);
        resetPinN = 1'h1;
        repeat (2) @(negedge clk_sys);
        check({7'h00, hostControlPortSpi_r}, 8'h00);
        rdChk(DAPR_OFS_POWER, DAPR_RST_POWER);
    endtask

    // -------------------------------------------------------
    // Clock, sequence and watchdog
    // -------------------------------------------------------
    // Free-running 200 MHz system clock.
    initial begin
        clk_sys = 1'h0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // Power-on reset, then every scenario in turn.
    initial begin
        reset = 1'h1;
        resetPinN = 1'h1;
        pixelClockInput = 1'h0;
        frameStart = 1'h0;
        spiSelect = 1'h0;
        cableSense = 2'h3;
        pinsIn = '0;
        repeat (16) @(negedge clk_sys);
        reset = 1'h0;
        @(negedge clk_sys);
        check({5'h00, dacPower_r}, {5'h00, DAPR_DAC_ALL});
        tComponent();
        tComposite();
        tDisabled();
        tReadback();
        tResets();
        completeRun();
    end

    // Cuts a hung run short.
    initial begin
        repeat (100000) @(posedge clk_sys);
        errCount++;
        completeRun();
    end
endmodule

`default_nettype wire
